//--- verilog/coam_addr_unit.sv
`timescale 1ns/1ps
`include "coam_defs.svh"

module coam_addr_unit (
    input  logic                   mclk,
    input  logic                   resetn,
    input  logic                   start,
    input  logic [4:0]             mode,
    input  logic                   use_y,
    input  logic                   rmw,
    input  logic [15:0]            pc_in,
    input  logic [7:0]             idx_x,
    input  logic [7:0]             idx_y,
    output logic                   mem_req,
    output logic [15:0]            mem_addr,
    input  logic                   mem_ack,
    input  logic [7:0]             mem_rdata,
    output logic                   busy,
    output logic                   done,
    output logic                   err,
    output logic [15:0]            ea,
    output logic [15:0]            target,
    output logic [7:0]             operand,
    output logic [2:0]             len,
    output logic [15:0]            next_pc,
    output coam_pkg::coam_family_t family
);
    coam_pkg::coam_state_t  state_r, state_nxt;
    logic [4:0]             mode_r, mode_nxt, dmode;
    logic                   y_r, y_nxt, dy;
    logic [7:0]             ixv_r, ixv_nxt;
    logic [15:0]            pc_r, pc_nxt;
    logic [15:0]            word_r, word_nxt;
    logic [7:0]             ptr_r, ptr_nxt;
    logic [7:0]             disp_r, disp_nxt;
    logic [1:0]             cnt_r, cnt_nxt;
    logic [1:0]             pcnt_r, pcnt_nxt;
    logic                   trail_r, trail_nxt;
    logic                   fail_r, fail_nxt;
    logic [15:0]            addr_r, addr_nxt;
    logic [2:0]             acks_r, acks_nxt;
    logic [2:0]             nexp_r, nexp_nxt;

    logic [1:0]             d_ops, d_ptr;
    logic                   d_trail, d_idx, d_long, d_rel, d_imm, d_bad;
    coam_pkg::coam_family_t d_fam;
    logic [2:0]             d_len;
    logic [15:0]            c_ea, c_target;
    logic                   take;

    // Decode the waiting request in idle, the latched one afterwards
    assign dmode = (state_r == coam_pkg::S_IDLE) ? mode : mode_r;
    assign dy    = (state_r == coam_pkg::S_IDLE) ? use_y : y_r;
    assign take  = mem_req && mem_ack;

    coam_mode_dec u_dec (
        .mode    (dmode),
        .use_y   (dy),
        .ops     (d_ops),
        .ptr     (d_ptr),
        .trail   (d_trail),
        .use_idx (d_idx),
        .is_long (d_long),
        .is_rel  (d_rel),
        .is_imm  (d_imm),
        .bad     (d_bad),
        .family  (d_fam),
        .len     (d_len)
    );

    coam_ea_calc u_calc (
        .word    (word_r),
        .idx     (ixv_r),
        .use_idx (d_idx),
        .pc      (pc_r),
        .disp    (d_rel ? word_r[7:0] : disp_r),
        .ea      (c_ea),
        .target  (c_target)
    );

    always_comb begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        y_nxt     = y_r;
        ixv_nxt   = ixv_r;
        pc_nxt    = pc_r;
        word_nxt  = word_r;
        ptr_nxt   = ptr_r;
        disp_nxt  = disp_r;
        cnt_nxt   = cnt_r;
        pcnt_nxt  = pcnt_r;
        trail_nxt = trail_r;
        fail_nxt  = fail_r;
        acks_nxt  = take ? acks_r + 3'h1 : acks_r;
        nexp_nxt  = nexp_r;
        unique case (state_r)
            coam_pkg::S_IDLE: begin
                if (start) begin
                    mode_nxt  = mode;
                    y_nxt     = use_y;
                    ixv_nxt   = use_y ? idx_y : idx_x;
                    pc_nxt    = pc_in;
                    word_nxt  = 16'h0000;
                    disp_nxt  = 8'h00;
                    cnt_nxt   = d_ops;
                    pcnt_nxt  = d_ptr;
                    trail_nxt = d_trail;
                    acks_nxt  = 3'h0;
                    nexp_nxt  = {1'b0, d_ops} + {1'b0, d_ptr}
                              + {2'h0, d_trail};
                    // Refused before any fetch so memory is not disturbed
                    fail_nxt  = d_bad || (rmw && d_long);
                    if (fail_nxt || d_ops == 2'h0) begin
                        state_nxt = coam_pkg::S_DONE;
                    end else begin
                        state_nxt = coam_pkg::S_OPND;
                    end
                end
            end
            coam_pkg::S_OPND: begin
                if (take) begin
                    // Earlier byte moves up: high byte first
                    word_nxt = {word_r[7:0], mem_rdata};
                    pc_nxt   = pc_r + 16'h0001;
                    cnt_nxt  = cnt_r - 2'h1;
                    if (cnt_r == 2'h1) begin
                        if (pcnt_r != 2'h0) begin
                            ptr_nxt   = mem_rdata;
                            word_nxt  = 16'h0000;
                            cnt_nxt   = pcnt_r;
                            state_nxt = coam_pkg::S_PTR;
                        end else if (trail_r) begin
                            state_nxt = coam_pkg::S_TRAIL;
                        end else begin
                            state_nxt = coam_pkg::S_DONE;
                        end
                    end
                end
            end
            coam_pkg::S_PTR: begin
                if (take) begin
                    word_nxt = {word_r[7:0], mem_rdata};
                    // Pointer bytes wrap inside page zero
                    ptr_nxt  = ptr_r + 8'h01;
                    cnt_nxt  = cnt_r - 2'h1;
                    if (cnt_r == 2'h1) begin
                        state_nxt = trail_r ? coam_pkg::S_TRAIL
                                            : coam_pkg::S_DONE;
                    end
                end
            end
            coam_pkg::S_TRAIL: begin
                if (take) begin
                    disp_nxt  = mem_rdata;
                    pc_nxt    = pc_r + 16'h0001;
                    state_nxt = coam_pkg::S_DONE;
                end
            end
            coam_pkg::S_DONE: begin
                state_nxt = coam_pkg::S_IDLE;
            end
            default: begin
                state_nxt = coam_pkg::S_IDLE;
            end
        endcase
        // One fetch per byte; long forms simply stay longer
        addr_nxt = (state_nxt == coam_pkg::S_PTR) ? {`COAM_PAGE0, ptr_nxt}
                                                  : pc_nxt;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= coam_pkg::S_IDLE;
            mode_r  <= 5'h00;
            y_r     <= 1'b0;
            ixv_r   <= 8'h00;
            pc_r    <= 16'h0000;
            word_r  <= 16'h0000;
            ptr_r   <= 8'h00;
            disp_r  <= 8'h00;
            cnt_r   <= 2'h0;
            pcnt_r  <= 2'h0;
            trail_r <= 1'b0;
            fail_r  <= 1'b0;
            addr_r  <= 16'h0000;
            acks_r  <= 3'h0;
            nexp_r  <= 3'h0;
        end else begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt;
            y_r     <= y_nxt;
            ixv_r   <= ixv_nxt;
            pc_r    <= pc_nxt;
            word_r  <= word_nxt;
            ptr_r   <= ptr_nxt;
            disp_r  <= disp_nxt;
            cnt_r   <= cnt_nxt;
            pcnt_r  <= pcnt_nxt;
            trail_r <= trail_nxt;
            fail_r  <= fail_nxt;
            addr_r  <= addr_nxt;
            acks_r  <= acks_nxt;
            nexp_r  <= nexp_nxt;
        end
    end

    assign mem_req  = (state_r == coam_pkg::S_OPND)
                   || (state_r == coam_pkg::S_PTR)
                   || (state_r == coam_pkg::S_TRAIL);
    assign mem_addr = addr_r;
    assign busy     = (state_r != coam_pkg::S_IDLE);

    // Results, loaded as the sequence closes
    logic                   done_r, done_nxt;
    logic                   err_r, err_nxt;
    logic [15:0]            ea_r, ea_nxt;
    logic [15:0]            tgt_r, tgt_nxt;
    logic [7:0]             opnd_r, opnd_nxt;
    logic [2:0]             len_r, len_nxt;
    logic [15:0]            npc_r, npc_nxt;
    coam_pkg::coam_family_t fam_r, fam_nxt;
    logic                   long_r, long_nxt;
    logic                   rel_r, rel_nxt;
    logic                   imm_r, imm_nxt;
    logic                   idx_r, idx_nxt;

    always_comb begin
        done_nxt = (state_r == coam_pkg::S_DONE);
        err_nxt  = err_r;
        ea_nxt   = ea_r;
        tgt_nxt  = tgt_r;
        opnd_nxt = opnd_r;
        len_nxt  = len_r;
        npc_nxt  = npc_r;
        fam_nxt  = fam_r;
        long_nxt = long_r;
        rel_nxt  = rel_r;
        imm_nxt  = imm_r;
        idx_nxt  = idx_r;
        if (state_r == coam_pkg::S_DONE) begin
            err_nxt  = fail_r;
            ea_nxt   = fail_r ? 16'h0000 : c_ea;
            tgt_nxt  = fail_r ? 16'h0000 : c_target;
            opnd_nxt = word_r[7:0];
            len_nxt  = d_len;
            npc_nxt  = pc_r;
            fam_nxt  = d_fam;
            long_nxt = d_long;
            rel_nxt  = d_rel;
            imm_nxt  = d_imm;
            idx_nxt  = d_idx;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
            ea_r   <= 16'h0000;
            tgt_r  <= 16'h0000;
            opnd_r <= 8'h00;
            len_r  <= 3'h0;
            npc_r  <= 16'h0000;
            fam_r  <= coam_pkg::F_INH;
            long_r <= 1'b0;
            rel_r  <= 1'b0;
            imm_r  <= 1'b0;
            idx_r  <= 1'b0;
        end else begin
            done_r <= done_nxt;
            err_r  <= err_nxt;
            ea_r   <= ea_nxt;
            tgt_r  <= tgt_nxt;
            opnd_r <= opnd_nxt;
            len_r  <= len_nxt;
            npc_r  <= npc_nxt;
            fam_r  <= fam_nxt;
            long_r <= long_nxt;
            rel_r  <= rel_nxt;
            imm_r  <= imm_nxt;
            idx_r  <= idx_nxt;
        end
    end

    assign done    = done_r;
    assign err     = err_r;
    assign ea      = ea_r;
    assign target  = tgt_r;
    assign operand = opnd_r;
    assign len     = len_r;
    assign next_pc = npc_r;
    assign family  = fam_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_family;
        done_r && !err_r |-> fam_r < `COAM_FAMILY_NUM;
    endproperty
    a_family: assert property (p_family)
        else $error("family code out of range");

    property p_short_page0;
        done_r && !err_r && !long_r && !rel_r && !idx_r
            |-> ea_r <= `COAM_SHORT_TOP;
    endproperty
    a_short_page0: assert property (p_short_page0)
        else $error("short form left page zero");

    property p_rmw_long;
        state_r == coam_pkg::S_IDLE && start && rmw && d_long
            |-> ##1 !mem_req ##1 done_r && err_r;
    endproperty
    a_rmw_long: assert property (p_rmw_long)
        else $error("long form accepted for read-modify-write");

    property p_inherent;
        state_r == coam_pkg::S_IDLE && start && !rmw
            && mode == coam_pkg::M_INH
            |-> ##1 !mem_req ##1 done_r && len_r == 3'h1;
    endproperty
    a_inherent: assert property (p_inherent)
        else $error("inherent form fetched or wrong length");

    property p_immediate;
        done_r && imm_r |-> len_r == 3'h2 && opnd_r == ea_r[7:0];
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("immediate length or operand wrong");

    property p_idx_none;
        done_r && mode_r == coam_pkg::M_IDX_0
            |-> ea_r == {8'h00, ixv_r} && len_r == (y_r ? 3'h2 : 3'h1);
    endproperty
    a_idx_none: assert property (p_idx_none)
        else $error("no-offset indexed address or length wrong");

    property p_idx_short;
        done_r && !err_r && idx_r && !long_r |-> ea_r <= `COAM_IDX_TOP;
    endproperty
    a_idx_short: assert property (p_idx_short)
        else $error("short indexed address beyond 1FE");

    property p_ptr_page0;
        state_r == coam_pkg::S_PTR |-> mem_req && mem_addr[15:8] == 8'h00;
    endproperty
    a_ptr_page0: assert property (p_ptr_page0)
        else $error("pointer read outside page zero");

    property p_high_first;
        state_r == coam_pkg::S_OPND && take && cnt_r == 2'h2
            |=> word_r[7:0] == $past(mem_rdata);
    endproperty
    a_high_first: assert property (p_high_first)
        else $error("first word byte not captured");

    property p_fetches;
        done_r && !err_r |-> acks_r == nexp_r;
    endproperty
    a_fetches: assert property (p_fetches)
        else $error("fetch count differs from mode");

    property p_branch;
        done_r && rel_r && !err_r
            |-> 16'(tgt_r - npc_r + `COAM_REL_BIAS) <= `COAM_SHORT_TOP;
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target out of reach");

    c_dir_long: cover property (done_r && mode_r == coam_pkg::M_DIR_L);
    c_ind_long: cover property (done_r && mode_r == coam_pkg::M_IND_L);
    c_rel_ind:  cover property (done_r && mode_r == coam_pkg::M_REL_I);
    c_refused:  cover property (done_r && err_r);

endmodule : coam_addr_unit

//--- shared/coam_defs.svh
`ifndef COAM_DEFS_SVH
`define COAM_DEFS_SVH

// Mode codes at or above this count are refused
`define COAM_MODE_NUM   5'h11
// Family codes stay below this count
`define COAM_FAMILY_NUM 3'h7
// High byte of every pointer read
`define COAM_PAGE0      8'h00
// Highest address of a short, non-indexed form
`define COAM_SHORT_TOP  16'h00FF
// Highest address of a short indexed form
`define COAM_IDX_TOP    16'h01FE
// Bias that maps a -128..+127 branch distance onto 0..255
`define COAM_REL_BIAS   16'h0080
// Bytes of the opcode itself
`define COAM_OPC_LEN    3'h1

`endif

//--- shared/coam_pkg.sv
package coam_pkg;

    typedef enum logic [4:0] {
        M_INH   = 5'h00,
        M_IMM   = 5'h01,
        M_DIR_S = 5'h02,
        M_DIR_L = 5'h03,
        M_IDX_0 = 5'h04,
        M_IDX_S = 5'h05,
        M_IDX_L = 5'h06,
        M_IND_S = 5'h07,
        M_IND_L = 5'h08,
        M_IIX_S = 5'h09,
        M_IIX_L = 5'h0A,
        M_REL_D = 5'h0B,
        M_REL_I = 5'h0C,
        M_BIT_D = 5'h0D,
        M_BIT_I = 5'h0E,
        M_BTR_D = 5'h0F,
        M_BTR_I = 5'h10
    } coam_mode_t;

    typedef enum logic [2:0] {
        F_INH = 3'h0,
        F_IMM = 3'h1,
        F_DIR = 3'h2,
        F_IDX = 3'h3,
        F_IND = 3'h4,
        F_REL = 3'h5,
        F_BIT = 3'h6
    } coam_family_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_OPND  = 3'h1,
        S_PTR   = 3'h2,
        S_TRAIL = 3'h3,
        S_DONE  = 3'h4
    } coam_state_t;

endpackage : coam_pkg

//--- verilog/coam_mode_dec.sv
`timescale 1ns/1ps
`include "coam_defs.svh"

module coam_mode_dec (
    input  logic [4:0]             mode,
    input  logic                   use_y,
    output logic [1:0]             ops,
    output logic [1:0]             ptr,
    output logic                   trail,
    output logic                   use_idx,
    output logic                   is_long,
    output logic                   is_rel,
    output logic                   is_imm,
    output logic                   bad,
    output coam_pkg::coam_family_t family,
    output logic [2:0]             len
);
    logic pre;

    always_comb begin
        ops     = 2'h0;
        ptr     = 2'h0;
        trail   = 1'b0;
        use_idx = 1'b0;
        is_long = 1'b0;
        is_rel  = 1'b0;
        is_imm  = 1'b0;
        pre     = 1'b0;
        bad     = 1'b0;
        family  = coam_pkg::F_INH;
        // Seventeen modes in seven families
        unique case (mode)
            coam_pkg::M_INH: begin
                family = coam_pkg::F_INH;
            end
            coam_pkg::M_IMM: begin
                ops    = 2'h1;
                is_imm = 1'b1;
                family = coam_pkg::F_IMM;
            end
            coam_pkg::M_DIR_S: begin
                ops    = 2'h1;
                family = coam_pkg::F_DIR;
            end
            coam_pkg::M_DIR_L: begin
                ops     = 2'h2;
                is_long = 1'b1;
                family  = coam_pkg::F_DIR;
            end
            coam_pkg::M_IDX_0: begin
                use_idx = 1'b1;
                pre     = use_y;
                family  = coam_pkg::F_IDX;
            end
            coam_pkg::M_IDX_S: begin
                ops     = 2'h1;
                use_idx = 1'b1;
                pre     = use_y;
                family  = coam_pkg::F_IDX;
            end
            coam_pkg::M_IDX_L: begin
                ops     = 2'h2;
                use_idx = 1'b1;
                is_long = 1'b1;
                pre     = use_y;
                family  = coam_pkg::F_IDX;
            end
            coam_pkg::M_IND_S: begin
                ops    = 2'h1;
                ptr    = 2'h1;
                pre    = 1'b1;
                family = coam_pkg::F_IND;
            end
            coam_pkg::M_IND_L: begin
                ops     = 2'h1;
                ptr     = 2'h2;
                is_long = 1'b1;
                pre     = 1'b1;
                family  = coam_pkg::F_IND;
            end
            coam_pkg::M_IIX_S: begin
                ops     = 2'h1;
                ptr     = 2'h1;
                use_idx = 1'b1;
                pre     = 1'b1;
                family  = coam_pkg::F_IND;
            end
            coam_pkg::M_IIX_L: begin
                ops     = 2'h1;
                ptr     = 2'h2;
                use_idx = 1'b1;
                is_long = 1'b1;
                pre     = 1'b1;
                family  = coam_pkg::F_IND;
            end
            coam_pkg::M_REL_D: begin
                ops    = 2'h1;
                is_rel = 1'b1;
                family = coam_pkg::F_REL;
            end
            coam_pkg::M_REL_I: begin
                ops    = 2'h1;
                ptr    = 2'h1;
                is_rel = 1'b1;
                pre    = 1'b1;
                family = coam_pkg::F_REL;
            end
            coam_pkg::M_BIT_D: begin
                ops    = 2'h1;
                family = coam_pkg::F_BIT;
            end
            coam_pkg::M_BIT_I: begin
                ops    = 2'h1;
                ptr    = 2'h1;
                pre    = 1'b1;
                family = coam_pkg::F_BIT;
            end
            coam_pkg::M_BTR_D: begin
                ops    = 2'h1;
                trail  = 1'b1;
                family = coam_pkg::F_BIT;
            end
            coam_pkg::M_BTR_I: begin
                ops    = 2'h1;
                ptr    = 2'h1;
                trail  = 1'b1;
                pre    = 1'b1;
                family = coam_pkg::F_BIT;
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        len = `COAM_OPC_LEN + {2'h0, pre} + {1'b0, ops} + {2'h0, trail};
    end

endmodule : coam_mode_dec

//--- verilog/coam_ea_calc.sv
`timescale 1ns/1ps

module coam_ea_calc (
    input  logic [15:0] word,
    input  logic [7:0]  idx,
    input  logic        use_idx,
    input  logic [15:0] pc,
    input  logic [7:0]  disp,
    output logic [15:0] ea,
    output logic [15:0] target
);
    // Short offsets arrive zero-extended, so the sum carries into bit 8
    assign ea     = word + (use_idx ? {8'h00, idx} : 16'h0000);
    // The pc given here already points past the whole instruction
    assign target = pc + {{8{disp[7]}}, disp};

endmodule : coam_ea_calc

//--- bench/coam_mem_model.sv
`timescale 1ns/1ps
module coam_mem_model (
    input  logic        mclk,
    input  logic        resetn,
    input  logic        slow,
    input  logic        mem_req,
    input  logic [15:0] mem_addr,
    output logic        mem_ack,
    output logic [7:0]  mem_rdata
);
    logic [1:0] wait_r;
    logic [1:0] wait_nxt;
    logic [7:0] byte_v;
    assign byte_v = mem_addr[7:0] ^ {mem_addr[11:8], mem_addr[15:12]} ^ 8'h5A;
    // Slow mode answers on the third cycle of each byte
    assign mem_ack = mem_req && (!slow || wait_r == 2'h2);
    // Not acked: inverse, so a stale sample never matches
    assign mem_rdata = mem_ack ? byte_v : ~byte_v;
    always_comb begin
        wait_nxt = (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) wait_r <= 2'h0;
        else wait_r <= wait_nxt;
    end
endmodule : coam_mem_model

//--- bench/tb_cpu_operand_address_modes.sv
`timescale 1ns/1ps
module tb_cpu_operand_address_modes;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        start = 1'b0;
    logic        use_y = 1'b0;
    logic        rmw = 1'b0;
    logic        slow = 1'b0;
    logic [4:0]  mode = 5'h00;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0]  idx_x = 8'h00;
    logic [7:0]  idx_y = 8'h00;
    logic        mem_req, mem_ack, busy, done, err;
    logic [15:0] mem_addr, ea, target, next_pc;
    logic [7:0]  mem_rdata, operand;
    logic [2:0]  len;
    coam_pkg::coam_family_t family;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc;

    always #20 mclk = ~mclk;

    coam_addr_unit DUT (.mclk, .resetn, .start, .mode, .use_y, .rmw,
        .pc_in, .idx_x, .idx_y, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
        .busy, .done, .err, .ea, .target, .operand, .len, .next_pc, .family);
    coam_mem_model mem (.mclk, .resetn, .slow, .mem_req, .mem_addr,
        .mem_ack, .mem_rdata);

    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
    endfunction : mb

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic go(input logic [4:0] m, input logic y, input logic r,
                      input logic [15:0] pc, input logic [7:0] x);
        @(posedge mclk);
        start <= 1'b1;
        mode <= m;
        use_y <= y;
        rmw <= r;
        pc_in <= pc;
        idx_x <= x;
        idx_y <= ~x;
        @(posedge mclk);
        start <= 1'b0;
        cyc = 0;
        do begin
            @(posedge mclk);
            #1;
            cyc++;
        end while (done !== 1'b1 && cyc < 100);
        // A run-out limit is a mismatch, not a silent skip
        if (done !== 1'b1) begin
            n_errors++;
            $display("wrong value done expected 1 seen %b", done);
        end
        chk("busy", 16'h0000, 16'(busy));
    endtask : go

    task automatic t_inh_imm;
        go(5'h00, 1'b0, 1'b0, 16'h0100, 8'h00);
        chk("cyc", 16'h0001, 16'(cyc));
        chk("len", 16'h0001, 16'(len));
        go(5'h01, 1'b0, 1'b0, 16'h1234, 8'h00);
        chk("opnd", 16'(mb(16'h1234)), 16'(operand));
        chk("len", 16'h0002, 16'(len));
    endtask : t_inh_imm

    task automatic t_dir;
        go(5'h02, 1'b0, 1'b0, 16'h0200, 8'h00);
        chk("ea", {8'h00, mb(16'h0200)}, ea);
        chk("cyc", 16'h0002, 16'(cyc));
        @(posedge mclk);
        slow <= 1'b1;
        go(5'h03, 1'b0, 1'b0, 16'h3456, 8'h00);
        chk("ea", {mb(16'h3456), mb(16'h3457)}, ea);
        chk("cyc", 16'h0007, 16'(cyc));
        chk("npc", 16'h3458, next_pc);
        @(posedge mclk);
        slow <= 1'b0;
    endtask : t_dir

    task automatic t_idx;
        go(5'h04, 1'b0, 1'b0, 16'h0500, 8'hC3);
        chk("ea", 16'h00C3, ea);
        chk("len", 16'h0001, 16'(len));
        go(5'h04, 1'b1, 1'b0, 16'h0500, 8'h81);
        chk("len", 16'h0002, 16'(len));
        chk("ea", 16'h007E, ea);
        go(5'h05, 1'b0, 1'b0, 16'h00A5, 8'hFF);
        chk("ea", 16'h01FE, ea);
        go(5'h06, 1'b1, 1'b0, 16'h2000, 8'h6F);
        chk("ea", {mb(16'h2000), mb(16'h2001)} + 16'h0090, ea);
    endtask : t_idx

    task automatic t_ind;
        logic [7:0] p;
        p = mb(16'h0300);
        go(5'h07, 1'b0, 1'b0, 16'h0300, 8'h00);
        chk("ea", {8'h00, mb({8'h00, p})}, ea);
        go(5'h08, 1'b0, 1'b0, 16'h0300, 8'h00);
        chk("ea", {mb({8'h00, p}), mb({8'h00, p + 8'h01})}, ea);
        chk("npc", 16'h0301, next_pc);
    endtask : t_ind

    task automatic t_rel;
        go(5'h0B, 1'b0, 1'b0, 16'h00A5, 8'h00);
        chk("tgt", 16'h00A5, target);
        go(5'h0B, 1'b0, 1'b0, 16'h1000, 8'h00);
        chk("tgt", 16'h105C, target);
    endtask : t_rel

    task automatic t_refuse;
        logic [15:0] f;
        go(5'h03, 1'b0, 1'b1, 16'h0600, 8'h00);
        chk("err", 16'h0001, 16'(err));
        go(5'h02, 1'b0, 1'b1, 16'h0600, 8'h00);
        chk("err", 16'h0000, 16'(err));
        go(5'h11, 1'b0, 1'b0, 16'h0600, 8'h00);
        chk("err", 16'h0001, 16'(err));
        for (int i = 0; i < 17; i++) begin
            go(5'(i), 1'b0, 1'b0, 16'h0400, 8'h10);
            f = 16'(i < 1 ? 0 : i < 2 ? 1 : i < 4 ? 2 : i < 7 ? 3 :
                i < 11 ? 4 : i < 13 ? 5 : 6);
            chk("fam", f, 16'(family));
        end
    endtask : t_refuse

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_inh_imm;
        t_dir;
        t_idx;
        t_ind;
        t_rel;
        t_refuse;
        report_and_stop;
    end

    // Whole run is under 1000 cycles
    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end
endmodule : tb_cpu_operand_address_modes
